// ==== include/alarm_defs.svh ====
/*
 * Offsets, reset values, field positions and timing counts of the alarm
 * handler. Assumes a 25 MHz system clock and a word-indexed register port.
 */
`ifndef ALARM_DEFS_SVH
`define ALARM_DEFS_SVH

// ==========================================================================
// Register offsets (word indices).
`define REG_OVERLOAD_TIME_LIMIT 16'h0180
`define REG_POSITION_ERROR_LIMIT 16'h0181
`define REG_NETWORK_LOSS_ENABLE 16'h6188
`define REG_ALARM_STATUS 16'h0100
`define REG_HOMING_CHECK_CFG 16'h0101

// ==========================================================================
// Reset values and ranges.
`define RST_OVERLOAD_TIME_LIMIT 32'h0000_0032
`define RST_POSITION_ERROR_LIMIT 32'h0000_012c
`define RST_NETWORK_LOSS_ENABLE 32'h0000_0001
`define RST_HOMING_CHECK_CFG 32'h0000_0003
`define OVERLOAD_TIME_MIN 32'h0000_0001
`define OVERLOAD_TIME_MAX 32'h0000_012c
`define POSITION_LIMIT_MIN 32'h0000_0001
`define POSITION_LIMIT_MAX 32'h0000_7530

// ==========================================================================
// Homing check configuration fields.
`define HOME_CFG_TIMING_BIT 0
`define HOME_CFG_SENSOR_IN_A_BIT 1

// ==========================================================================
// Timing: overload time unit is 0.1 s.
`define CLK_HZ 25000000
`define OVERLOAD_UNIT_MS 100
`define OVERLOAD_UNIT_CYCLES (`CLK_HZ / 1000 * `OVERLOAD_UNIT_MS)

// ==========================================================================
// Alarm status bit positions.
`define ALM_HOMING_SIGNAL 0
`define ALM_OVERTRAVEL 1
`define ALM_SAFE_TORQUE_OFF 2
`define ALM_HOMING_OFFSET 3
`define ALM_MECH_OVERTRAVEL 4
`define ALM_OPERATION_DATA 5
`define ALM_GEAR_SETTING 6
`define ALM_WRAP_SETTING 7
`define ALM_NETWORK_LOSS 8
`define ALM_NETWORK_MODULE 9
`define ALM_PROCESSOR 10
`define ALM_OVERLOAD 11
`define ALM_POSITION_ERROR 12
`define ALM_MOTOR_COMBINATION 13
`define ALM_COUNT 14

`endif

// ==== include/alarm_pkg.sv ====
/*
 * Types of the alarm handler. Assumes alarm_defs.svh for the bit count.
 */
`include "alarm_defs.svh"

package alarm_pkg;

	// ======================================================================
	// Alarm vector and supply kinds.
	typedef logic [`ALM_COUNT-1:0] alarm_vec_t;

	typedef enum logic {
		supply_dc,
		supply_ac
	} supply_kind_e;

endpackage

// ==== hdl/alarm_latch.sv ====
/*
 * One latched alarm bit with its clearing method and excitation class.
 * Assumes the caller supplies a clean one-cycle clear request.
 */
`timescale 1ns/1ps

module alarm_latch #(
	parameter bit CLEARABLE = 1'b1,
	parameter bit KEEP_EXCITED = 1'b1
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic detect_in,
	input wire logic clear_in,
	input wire logic clear_allowed_in,
	output logic active_out,
	output logic deexcite_out
);

	logic alarm_ff;
	logic nxt_alarm;

	// ======================================================================
	// Latch.
	// Detection wins over a clear in the same cycle so no event is lost.
	always_comb begin
		nxt_alarm = alarm_ff;
		if (detect_in) begin
			nxt_alarm = 1'b1;
		end else if (CLEARABLE && clear_in && clear_allowed_in) begin
			nxt_alarm = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			alarm_ff <= 1'b0;
		end else begin
			alarm_ff <= nxt_alarm;
		end
	end

	assign active_out = alarm_ff;
	assign deexcite_out = alarm_ff & ~KEEP_EXCITED;

endmodule // alarm_latch

// ==== hdl/motor_driver_alarm_handler.sv ====
/*
 * Alarm handler of a stepper driver: latches faults, drops the status
 * outputs, stops or de-energizes the motor, holds alarm thresholds.
 * Assumes synchronous inputs and a power-on reset standing for a control
 * power cycle.
 */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "alarm_defs.svh"

module motor_driver_alarm_handler
	import alarm_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic fault_clear_in,
	input wire logic safe_torque_off_in_a,
	input wire logic safe_torque_off_in_b,
	input wire logic home_sensor_in,
	input wire logic homing_active_in,
	input wire logic step_timing_out,
	input wire logic zero_phase_out,
	input wire logic sensor_in_a,
	input wire logic overtravel_in,
	input wire logic homing_offset_fault_in,
	input wire logic mech_overtravel_in,
	input wire logic operation_data_fault_in,
	input wire logic gear_setting_fault_in,
	input wire logic wrap_setting_fault_in,
	input wire logic network_connected_in,
	input wire logic network_module_fault_in,
	input wire logic processor_fault_in,
	input wire logic overload_in,
	input wire logic [31:0] position_deviation_in,
	input wire logic motor_supply_ac_in,
	input wire logic motor_small_frame_in,
	input wire logic supply_48v_in,
	input wire logic motion_request_in,
	output logic alarm_ok_out,
	output logic ready_out,
	output logic motion_active_out,
	output logic pulse_accept_ready_out,
	output logic motor_stop_out,
	output logic motor_excite_out
);

	localparam supply_kind_e DRIVER_SUPPLY = supply_dc;
	localparam int OVL_CYC = `OVERLOAD_UNIT_CYCLES;
	// Reset words of the narrow registers; only their low bits are kept.
	localparam logic [31:0] NET_EN_RST = `RST_NETWORK_LOSS_ENABLE;
	localparam logic [31:0] HOME_CFG_RST = `RST_HOMING_CHECK_CFG;

	// ======================================================================
	// Registers.
	logic [31:0] ovl_limit_ff, nxt_ovl_limit;
	logic [31:0] pos_limit_ff, nxt_pos_limit;
	logic net_en_ff, nxt_net_en;
	logic [1:0] home_cfg_ff, nxt_home_cfg;
	logic [31:0] rdata_ff, nxt_rdata;
	alarm_vec_t alarm_act;
	alarm_vec_t alarm_deexc;
	alarm_vec_t detect;

	// Out-of-range writes are clamped so the thresholds stay meaningful.
	always_comb begin
		nxt_ovl_limit = ovl_limit_ff;
		nxt_pos_limit = pos_limit_ff;
		nxt_net_en = net_en_ff;
		nxt_home_cfg = home_cfg_ff;
		nxt_rdata = 32'h0000_0000;
		if (reg_wr_in) begin
			if (reg_addr_in == `REG_OVERLOAD_TIME_LIMIT) begin
				if (reg_wdata_in < `OVERLOAD_TIME_MIN) begin
					nxt_ovl_limit = `OVERLOAD_TIME_MIN;
				end else if (reg_wdata_in > `OVERLOAD_TIME_MAX) begin
					nxt_ovl_limit = `OVERLOAD_TIME_MAX;
				end else begin
					nxt_ovl_limit = reg_wdata_in;
				end
			end else if (reg_addr_in == `REG_POSITION_ERROR_LIMIT) begin
				if (reg_wdata_in < `POSITION_LIMIT_MIN) begin
					nxt_pos_limit = `POSITION_LIMIT_MIN;
				end else if (reg_wdata_in > `POSITION_LIMIT_MAX) begin
					nxt_pos_limit = `POSITION_LIMIT_MAX;
				end else begin
					nxt_pos_limit = reg_wdata_in;
				end
			end else if (reg_addr_in == `REG_NETWORK_LOSS_ENABLE) begin
				nxt_net_en = reg_wdata_in[0];
			end else if (reg_addr_in == `REG_HOMING_CHECK_CFG) begin
				nxt_home_cfg = reg_wdata_in[1:0];
			end
		end
		if (reg_rd_in) begin
			if (reg_addr_in == `REG_OVERLOAD_TIME_LIMIT) begin
				nxt_rdata = ovl_limit_ff;
			end else if (reg_addr_in == `REG_POSITION_ERROR_LIMIT) begin
				nxt_rdata = pos_limit_ff;
			end else if (reg_addr_in == `REG_NETWORK_LOSS_ENABLE) begin
				nxt_rdata = {31'h0000_0000, net_en_ff};
			end else if (reg_addr_in == `REG_HOMING_CHECK_CFG) begin
				nxt_rdata = {30'h0000_0000, home_cfg_ff};
			end else if (reg_addr_in == `REG_ALARM_STATUS) begin
				nxt_rdata = {{(32-`ALM_COUNT){1'b0}}, alarm_act};
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			ovl_limit_ff <= `RST_OVERLOAD_TIME_LIMIT;
			pos_limit_ff <= `RST_POSITION_ERROR_LIMIT;
			net_en_ff <= NET_EN_RST[0];
			home_cfg_ff <= HOME_CFG_RST[1:0];
			rdata_ff <= 32'h0000_0000;
		end else begin
			ovl_limit_ff <= nxt_ovl_limit;
			pos_limit_ff <= nxt_pos_limit;
			net_en_ff <= nxt_net_en;
			home_cfg_ff <= nxt_home_cfg;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_out = rdata_ff;

	// ======================================================================
	// Overload timer and clear edge.
	logic [31:0] tick_ff, nxt_tick;
	logic [31:0] units_ff, nxt_units;
	logic clr_d_ff, nxt_clr_d;
	logic clear_pulse;

	// The count restarts whenever overload_in drops, so only a continuous
	// overload raises the alarm. The unit count stops at the limit.
	always_comb begin
		nxt_tick = 32'h0000_0000;
		nxt_units = 32'h0000_0000;
		if (overload_in) begin
			nxt_units = units_ff;
			nxt_tick = tick_ff + 32'h0000_0001;
			if (tick_ff == 32'(OVL_CYC - 1)) begin
				nxt_tick = 32'h0000_0000;
				if (units_ff < ovl_limit_ff) begin
					nxt_units = units_ff + 32'h0000_0001;
				end
			end
		end
		nxt_clr_d = fault_clear_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			tick_ff <= 32'h0000_0000;
			units_ff <= 32'h0000_0000;
			clr_d_ff <= 1'b0;
		end else begin
			tick_ff <= nxt_tick;
			units_ff <= nxt_units;
			clr_d_ff <= nxt_clr_d;
		end
	end

	// Only the rising edge clears, so a held clear cannot mask a new alarm.
	assign clear_pulse = fault_clear_in & ~clr_d_ff;

	// ======================================================================
	// Detection.
	logic home_bad;
	logic stos_ok;
	logic comb_bad;

	// A homing check whose enable bit is 0 is skipped, for machines that
	// do not wire that signal.
	assign home_bad = homing_active_in & home_sensor_in &
		((home_cfg_ff[`HOME_CFG_TIMING_BIT] &
		~(step_timing_out & zero_phase_out)) |
		(home_cfg_ff[`HOME_CFG_SENSOR_IN_A_BIT] & ~sensor_in_a));
	assign stos_ok = safe_torque_off_in_a & safe_torque_off_in_b;
	assign comb_bad = (motor_supply_ac_in != (DRIVER_SUPPLY == supply_ac)) |
		(motor_small_frame_in & supply_48v_in);

	always_comb begin
		detect = '0;
		detect[`ALM_HOMING_SIGNAL] = home_bad;
		detect[`ALM_OVERTRAVEL] = overtravel_in;
		detect[`ALM_SAFE_TORQUE_OFF] = ~stos_ok;
		detect[`ALM_HOMING_OFFSET] = homing_offset_fault_in;
		detect[`ALM_MECH_OVERTRAVEL] = mech_overtravel_in;
		detect[`ALM_OPERATION_DATA] = operation_data_fault_in;
		detect[`ALM_GEAR_SETTING] = gear_setting_fault_in;
		detect[`ALM_WRAP_SETTING] = wrap_setting_fault_in;
		detect[`ALM_NETWORK_LOSS] = net_en_ff & ~network_connected_in;
		detect[`ALM_NETWORK_MODULE] = network_module_fault_in;
		detect[`ALM_PROCESSOR] = processor_fault_in;
		detect[`ALM_OVERLOAD] = overload_in & (units_ff >= ovl_limit_ff);
		detect[`ALM_POSITION_ERROR] = position_deviation_in > pos_limit_ff;
		detect[`ALM_MOTOR_COMBINATION] = comb_bad;
	end

	// ======================================================================
	// Latches: clearable and excitation classes per alarm.
	// A set bit of CLR_MASK lets the fault-clear edge clear that alarm; the
	// others wait for a power cycle. A set bit of EXC_MASK keeps the motor
	// energized while that alarm stands.
	localparam logic [`ALM_COUNT-1:0] CLR_MASK = 14'h393f;
	localparam logic [`ALM_COUNT-1:0] EXC_MASK = 14'h193b;

	// Only the torque-off alarm waits for its inputs before a clear counts.
	alarm_vec_t clear_ok;

	always_comb begin
		clear_ok = '1;
		clear_ok[`ALM_SAFE_TORQUE_OFF] = stos_ok;
	end

	genvar g;
	generate
		for (g = 0; g < `ALM_COUNT; g = g + 1) begin : g_alm
			alarm_latch #(
				.CLEARABLE(CLR_MASK[g]),
				.KEEP_EXCITED(EXC_MASK[g])
			) u_latch (
				.clk_sys_in(clk_sys_in),
				.rst_b_in(rst_b_in),
				.detect_in(detect[g]),
				.clear_in(clear_pulse),
				.clear_allowed_in(clear_ok[g]),
				.active_out(alarm_act[g]),
				.deexcite_out(alarm_deexc[g])
			);
		end
	endgenerate

	// ======================================================================
	// Outputs. They follow the raw detect too, so they drop in the same
	// cycle the fault is seen rather than one cycle later.
	logic any_alarm;
	logic ok_ff, rdy_ff, mov_ff, pls_ff, stop_ff, exc_ff;
	logic nxt_ok, nxt_rdy, nxt_mov, nxt_pls, nxt_stop, nxt_exc;

	always_comb begin
		any_alarm = (|merged_alarms(alarm_act, detect));
		nxt_ok = ~any_alarm;
		nxt_rdy = ~any_alarm;
		nxt_pls = ~any_alarm;
		nxt_mov = ~any_alarm & motion_request_in;
		nxt_stop = any_alarm;
		nxt_exc = ~(|(alarm_deexc | (detect & ~EXC_MASK)));
	end

	// Latched and fresh faults together, so the outputs drop on the edge
	// that first sees a fault.
	function automatic alarm_vec_t merged_alarms(input alarm_vec_t a,
		input alarm_vec_t d);
		merged_alarms = a | d;
	endfunction

	// During reset the motor is held stopped and unexcited.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			ok_ff <= 1'b0;
			rdy_ff <= 1'b0;
			mov_ff <= 1'b0;
			pls_ff <= 1'b0;
			stop_ff <= 1'b1;
			exc_ff <= 1'b0;
		end else begin
			ok_ff <= nxt_ok;
			rdy_ff <= nxt_rdy;
			mov_ff <= nxt_mov;
			pls_ff <= nxt_pls;
			stop_ff <= nxt_stop;
			exc_ff <= nxt_exc;
		end
	end

	assign alarm_ok_out = ok_ff;
	assign ready_out = rdy_ff;
	assign motion_active_out = mov_ff;
	assign pulse_accept_ready_out = pls_ff;
	assign motor_stop_out = stop_ff;
	assign motor_excite_out = exc_ff;

endmodule // motor_driver_alarm_handler

// ==== tb/alarm_handler_sva.sv ====
/* Checker of the alarm handler port behaviour.
   Assumes it is bound to the handler's top module. */
`timescale 1ns/1ps
// ======================================
// Assertions.
module alarm_handler_sva (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic fault_clear_in,
	input wire logic overtravel_in,
	input wire logic gear_setting_fault_in,
	input wire logic processor_fault_in,
	input wire logic safe_torque_off_in_a,
	input wire logic safe_torque_off_in_b,
	input wire logic alarm_ok_out,
	input wire logic ready_out,
	input wire logic motion_active_out,
	input wire logic pulse_accept_ready_out,
	input wire logic motor_stop_out,
	input wire logic motor_excite_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	// The first rise of alarm-ok after reset needs no clear.
	logic up_ff;
	logic nxt_up;
	always_comb nxt_up = up_ff | alarm_ok_out;
	always_ff @(posedge clk_sys_in) begin
		up_ff <= rst_b_in ? nxt_up : 1'b0;
	end
	sequence s_halted;
		!alarm_ok_out && !ready_out && !motion_active_out
		&& !pulse_accept_ready_out && motor_stop_out;
	endsequence
	AST_ALARM_HALTS: assert property (
		$past(rst_b_in) && overtravel_in |=> s_halted)
		else $error("outputs not halted after alarm");
	AST_LOW_OK_HALTS: assert property (!alarm_ok_out |-> s_halted)
		else $error("motion allowed while alarm present");
	AST_GEAR_DEEXCITE: assert property (
		$past(rst_b_in) && gear_setting_fault_in |=> !motor_excite_out)
		else $error("gear fault left motor excited");
	AST_GEAR_STICKY: assert property (
		$past(rst_b_in) && gear_setting_fault_in |=> (!alarm_ok_out)[*8])
		else $error("gear fault cleared early");
	AST_CPU_STICKY: assert property (
		$past(rst_b_in) && processor_fault_in |=> (!alarm_ok_out)[*8])
		else $error("processor fault cleared");
	AST_STO_DEEXCITE: assert property ($past(rst_b_in) &&
		!(safe_torque_off_in_a && safe_torque_off_in_b) |=> !motor_excite_out)
		else $error("torque off left motor excited");
	AST_STO_HOLDS: assert property ($past(rst_b_in) &&
		!(safe_torque_off_in_a && safe_torque_off_in_b) |=> !alarm_ok_out)
		else $error("torque off left alarm-ok active");
	AST_OK_NEEDS_CLEAR: assert property (
		up_ff && $rose(alarm_ok_out) |-> $past(fault_clear_in, 2))
		else $error("alarm left without clear");
	AST_DEEXCITE_STOPS: assert property (!motor_excite_out |-> motor_stop_out)
		else $error("motor not stopped while unexcited");
endmodule // alarm_handler_sva

bind motor_driver_alarm_handler alarm_handler_sva u_sva (
	.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
	.fault_clear_in(fault_clear_in), .overtravel_in(overtravel_in),
	.gear_setting_fault_in(gear_setting_fault_in),
	.processor_fault_in(processor_fault_in),
	.safe_torque_off_in_a(safe_torque_off_in_a),
	.safe_torque_off_in_b(safe_torque_off_in_b),
	.alarm_ok_out(alarm_ok_out), .ready_out(ready_out),
	.motion_active_out(motion_active_out),
	.pulse_accept_ready_out(pulse_accept_ready_out),
	.motor_stop_out(motor_stop_out), .motor_excite_out(motor_excite_out));

// ==== tb/host_model.sv ====
/* Host controller model: halts the pulse input and operates fault clear.
   Assumes the driver's alarm-ok output and a go pulse from the bench. */
`timescale 1ns/1ps
// ======================================
// Host.
module host_model (
	input wire logic clk_sys_in,
	input wire logic go_in,
	input wire logic alarm_ok_in,
	output logic fault_clear_out,
	output logic pulse_run_out,
	output logic done_out
);
	int n;
	initial begin
		fault_clear_out = 1'b0;
		pulse_run_out = 1'b1;
		done_out = 1'b0;
	end
	// A reset with pulses arriving could jerk the motor, so halt first.
	always @(posedge clk_sys_in) begin
		if (go_in) begin
			pulse_run_out <= 1'b0;
			@(posedge clk_sys_in);
			fault_clear_out <= 1'b1;
			n = 0;
			do begin
				@(posedge clk_sys_in);
				n++;
			end while (!alarm_ok_in && n < 12);
			fault_clear_out <= 1'b0;
			pulse_run_out <= 1'b1;
			done_out <= 1'b1;
			@(posedge clk_sys_in);
			done_out <= 1'b0;
		end
	end
endmodule // host_model

// ==== tb/motor_driver_alarm_handler_test.sv ====
/* Self-checking bench of the alarm handler.
   Assumes the host model operates fault clear and the pulse input. */
`timescale 1ns/1ps
`include "alarm_defs.svh"
// ======================================
// Bench.
module motor_driver_alarm_handler_test;
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [15:0] addr = '0;
	logic [15:0] f = '0;
	logic [31:0] wd = '0;
	logic [31:0] dev = '0;
	logic [31:0] rdata;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic ok, rdy, mot, pls, stp, exc, fclr, mreq, hdone;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	// {clearable, excited, fault mask}
	localparam logic [17:0] TV [13] = '{18'h3_0001, 18'h3_0002,
		18'h2_0004, 18'h3_0008, 18'h3_0010, 18'h3_0020, 18'h3_0100,
		18'h2_2000, 18'h2_c000, 18'h0_0040, 18'h0_0080, 18'h0_0200,
		18'h0_0400};
	always #20 clk_sys_in = ~clk_sys_in;
	motor_driver_alarm_handler u_motor_driver_alarm_handler (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .fault_clear_in(fclr),
		.safe_torque_off_in_a(~f[2]), .safe_torque_off_in_b(~f[2]),
		.home_sensor_in(1'b1), .homing_active_in(f[0]),
		.step_timing_out(~f[0]), .zero_phase_out(1'b1),
		.sensor_in_a(1'b1), .overtravel_in(f[1]),
		.homing_offset_fault_in(f[3]), .mech_overtravel_in(f[4]),
		.operation_data_fault_in(f[5]), .gear_setting_fault_in(f[6]),
		.wrap_setting_fault_in(f[7]), .network_connected_in(~f[8]),
		.network_module_fault_in(f[9]), .processor_fault_in(f[10]),
		.overload_in(f[11]), .position_deviation_in(dev),
		.motor_supply_ac_in(f[13]), .motor_small_frame_in(f[14]),
		.supply_48v_in(f[15]), .motion_request_in(mreq),
		.alarm_ok_out(ok), .ready_out(rdy), .motion_active_out(mot),
		.pulse_accept_ready_out(pls), .motor_stop_out(stp),
		.motor_excite_out(exc));
	host_model u_host_model (.clk_sys_in(clk_sys_in), .go_in(go),
		.alarm_ok_in(ok), .fault_clear_out(fclr), .pulse_run_out(mreq),
		.done_out(hdone));
	task summarize;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			summarize;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wreg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask
	task rreg(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task clr;
		int n;
		@(posedge clk_sys_in);
		go <= 1'b1;
		@(posedge clk_sys_in);
		go <= 1'b0;
		for (n = 0; n < 30 && hdone !== 1'b1; n++) begin
			@(posedge clk_sys_in);
			#1;
		end
		@(posedge clk_sys_in);
		#1;
	endtask
	task settle(input logic [15:0] m, input logic [31:0] d);
		@(posedge clk_sys_in);
		f <= m;
		dev <= d;
		repeat (3) @(posedge clk_sys_in);
		#1;
	endtask
	task try(input logic [17:0] t);
		settle(t[15:0], 0);
		chk("halt", {4'h0, 1'b1, t[16]}, {ok, rdy, pls, mot, stp, exc});
		clr;
		chk("clear while present", 0, ok);
		settle(0, 0);
		chk("latched", 0, ok);
		clr;
		chk("clear", {{4{t[17]}}, ~t[17], t[17]},
			{ok, rdy, pls, mot, stp, exc});
		if (!t[17]) begin
			@(posedge clk_sys_in);
			rst_b_in <= 1'b0;
			repeat (3) @(posedge clk_sys_in);
			rst_b_in <= 1'b1;
			repeat (3) @(posedge clk_sys_in);
			#1 chk("power cycle", 6'h3d,
				{ok, rdy, pls, mot, stp, exc});
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rreg(`REG_OVERLOAD_TIME_LIMIT, `RST_OVERLOAD_TIME_LIMIT);
		rreg(`REG_POSITION_ERROR_LIMIT, `RST_POSITION_ERROR_LIMIT);
		rreg(`REG_NETWORK_LOSS_ENABLE, `RST_NETWORK_LOSS_ENABLE);
		rreg(`REG_HOMING_CHECK_CFG, `RST_HOMING_CHECK_CFG);
		rreg(16'h0200, 32'h0000_0000);
		wreg(`REG_OVERLOAD_TIME_LIMIT, 32'h0000_0000);
		rreg(`REG_OVERLOAD_TIME_LIMIT, `OVERLOAD_TIME_MIN);
		wreg(`REG_POSITION_ERROR_LIMIT, 32'hffff_ffff);
		rreg(`REG_POSITION_ERROR_LIMIT, `POSITION_LIMIT_MAX);
		$display("register test done");
		for (int i = 0; i < 13; i++) try(TV[i]);
		$display("alarm table test done");
		wreg(`REG_POSITION_ERROR_LIMIT, 32'h0000_0005);
		settle(0, 5);
		chk("deviation at limit", 1, ok);
		settle(0, 6);
		chk("deviation above limit", 0, ok);
		rreg(`REG_ALARM_STATUS, 32'h0000_1000);
		settle(0, 0);
		clr;
		chk("deviation cleared", 1, ok);
		settle(16'h0800, 0);
		chk("overload too short", 1, ok);
		wreg(`REG_NETWORK_LOSS_ENABLE, 32'h0000_0000);
		settle(16'h0100, 0);
		chk("network loss disabled", 1, ok);
		wreg(`REG_HOMING_CHECK_CFG, 32'h0000_0000);
		settle(16'h0001, 0);
		chk("homing check disabled", 1, ok);
		settle(0, 0);
		$display("limit test done");
		summarize;
	end
endmodule // motor_driver_alarm_handler_test
